// *** ptx_serial_tx.sv ***
// Parallel pixel capture and seven-slot serialiser for four data lanes and a clock lane
// Overview of operation
// - All pixel data inputs are captured on the rising edge of the pixel clock.
// - Sleep input low puts all data and clock outputs into high impedance.
// - Four differential data lanes and one differential clock lane are driven.
// - Each clock period carries seven evenly spaced bit slots, zero to six.
// - Serial output becomes valid only after a lock time of at least 10 ms of running pixel clock.
// - Outputs reach high impedance within 100 ns after sleep goes low.
// - All 28 bits are sampled and sent in every pixel clock cycle.
`timescale 1ns/100ps
module ptx_serial_tx
   import ptx_pkg::*;
#(
   parameter int LOCK_CYC = PLL_LOCK_CYC
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // Parallel side
   input  wire ptx_pixel_t           parallel_pixel_inputs,
   input  wire logic                 pixel_shift_clock_in,
   input  wire logic                 sleep_control_n,
   // Serial side
   output      logic [PTX_LANES-1:0] serial_data_lanes_p,
   output      logic [PTX_LANES-1:0] serial_data_lanes_n,
   output      logic                 serial_data_lanes_oe,
   output      logic                 forwarded_link_clock_p,
   output      logic                 forwarded_link_clock_n,
   output      logic                 forwarded_link_clock_oe,
   // Status
   output      logic                 link_locked
);

   // ==========================================================
   // Pin synchronisation
   localparam int SYNC_W = PTX_WORD_W + 2;

   logic [SYNC_W-1:0] pins_sync;
   ptx_pixel_t        pix_sync;
   logic              pclk_sync;
   logic              awake_sync;

   ptx_sync #(.WIDTH(SYNC_W)) u_sync (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .pins      ({parallel_pixel_inputs, pixel_shift_clock_in, sleep_control_n}),
      .pins_sync (pins_sync)
   );

   assign pix_sync   = ptx_pixel_t'(pins_sync[SYNC_W-1:2]);
   assign pclk_sync  = pins_sync[1];
   assign awake_sync = pins_sync[0];

   // ==========================================================
   // State
   typedef struct packed {
      ptx_state_t              state;
      logic                    pclk_prev;
      ptx_pixel_t              pix_prev;
      ptx_pixel_t              word;
      logic [PER_W-1:0]        cnt;
      logic [PER_W-1:0]        per;
      logic [PER_W:0]          acc;
      logic [PTX_SLOT_W-1:0]   slot;
      logic [LOCK_W-1:0]       lock_cnt;
      logic                    locked;
      ptx_link_t               link;
   } ptx_tx_st_t;

   ptx_tx_st_t st_ff;
   ptx_tx_st_t nxt_st;
   logic       pclk_rise;
   logic       clk_lost;
   logic [PER_W:0] acc_step;

   assign pclk_rise = pclk_sync && !st_ff.pclk_prev;
   assign clk_lost  = (st_ff.cnt == PER_MAX);
   assign acc_step  = st_ff.acc + (PER_W+1)'(PTX_SLOTS);

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pclk_prev = pclk_sync;
      // Value held just before the edge already met its setup time
      nxt_st.pix_prev  = pix_sync;
      if (st_ff.cnt != PER_MAX) begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end
      if (pclk_rise) begin
         nxt_st.word = st_ff.pix_prev;
         nxt_st.per  = st_ff.cnt + 1'b1;
         nxt_st.cnt  = '0;
         nxt_st.acc  = '0;
         nxt_st.slot = '0;
      end else if (st_ff.slot != PTX_LAST_SLOT) begin
         // Slots spread evenly over the measured period
         if (acc_step >= {1'b0, st_ff.per}) begin
            nxt_st.acc  = acc_step - {1'b0, st_ff.per};
            nxt_st.slot = st_ff.slot + 1'b1;
         end else begin
            nxt_st.acc  = acc_step;
         end
      end

      case (st_ff.state)
         ST_SLEEP: begin
            nxt_st.lock_cnt = '0;
            nxt_st.locked   = 1'b0;
            if (awake_sync) begin
               nxt_st.state = ST_ACQUIRE;
            end
         end
         ST_ACQUIRE: begin
            // Lock waits for a running pixel clock for the full lock time
            if (clk_lost) begin
               nxt_st.lock_cnt = '0;
            end else if (st_ff.lock_cnt == LOCK_W'(LOCK_CYC - 1)) begin
               nxt_st.state  = ST_RUN;
               nxt_st.locked = 1'b1;
            end else begin
               nxt_st.lock_cnt = st_ff.lock_cnt + 1'b1;
            end
         end
         ST_RUN: begin
            if (clk_lost) begin
               nxt_st.state    = ST_ACQUIRE;
               nxt_st.locked   = 1'b0;
               nxt_st.lock_cnt = '0;
            end
         end
         default: begin
            nxt_st.state = ST_SLEEP;
         end
      endcase
      if (!awake_sync) begin
         nxt_st.state = ST_SLEEP;
         nxt_st.locked = 1'b0;
      end

      // Output stage follows the next slot so lanes and state stay aligned
      nxt_st.link.oe = (nxt_st.state != ST_SLEEP);
      for (int l = 0; l < PTX_LANES; l++) begin
         nxt_st.link.lane_p[l] = (nxt_st.state == ST_RUN) &&
                                 nxt_st.word[l*PTX_SLOTS + int'(nxt_st.slot)];
      end
      nxt_st.link.clk_p = (nxt_st.state == ST_RUN) &&
                          (nxt_st.slot < PTX_CLK_HI_SLOTS);
      nxt_st.link.lane_n = ~nxt_st.link.lane_p;
      nxt_st.link.clk_n  = ~nxt_st.link.clk_p;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff       <= '0;
         st_ff.state <= ST_SLEEP;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign serial_data_lanes_p     = st_ff.link.lane_p;
   assign serial_data_lanes_n     = st_ff.link.lane_n;
   assign serial_data_lanes_oe    = st_ff.link.oe;
   assign forwarded_link_clock_p  = st_ff.link.clk_p;
   assign forwarded_link_clock_n  = st_ff.link.clk_n;
   assign forwarded_link_clock_oe = st_ff.link.oe;
   assign link_locked             = st_ff.locked;

   // ==========================================================
   // Assertions
   localparam int LANE_SEL = 2;
   localparam int SLEEP_CHK = 4;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_CAPTURE: assert property (pclk_rise |=> st_ff.word == $past(st_ff.pix_prev))
      else $error("word not captured at pixel clock edge");
   AST_EVERY_CYCLE: assert property (pclk_rise ##1 (!pclk_rise [*2]) |->
      st_ff.word == $past(st_ff.word))
      else $error("captured word changed between edges");
   AST_SLEEP_HIZ: assert property (!awake_sync |=> !serial_data_lanes_oe &&
      !forwarded_link_clock_oe)
      else $error("outputs driven while asleep");
   AST_SLEEP_DELAY: assert property (!sleep_control_n [*4] |-> !serial_data_lanes_oe)
      else $error("sleep entry slower than allowed");
   AST_DIFF: assert property (serial_data_lanes_oe |-> (serial_data_lanes_n == ~serial_data_lanes_p)
      && (forwarded_link_clock_n == ~forwarded_link_clock_p))
      else $error("differential pair not complementary");
   AST_SLOT_RANGE: assert property (st_ff.slot <= PTX_LAST_SLOT)
      else $error("slot index out of range");
   // A slot return to zero follows the rise seen one cycle earlier
   AST_SLOT_STEP: assert property (!$past(pclk_rise) && st_ff.slot != $past(st_ff.slot) |->
      st_ff.slot == $past(st_ff.slot) + 3'h1)
      else $error("slot skipped");
   AST_LANE_MAP: assert property (st_ff.state == ST_RUN |->
      serial_data_lanes_p[LANE_SEL] == st_ff.word[LANE_SEL*PTX_SLOTS + int'(st_ff.slot)])
      else $error("lane bit does not follow slot order");
   AST_FWD_CLK: assert property (st_ff.state == ST_RUN |->
      forwarded_link_clock_p == (st_ff.slot < PTX_CLK_HI_SLOTS))
      else $error("forwarded clock not aligned to slots");
   AST_LOCK_QUIET: assert property (st_ff.state == ST_ACQUIRE |-> !link_locked &&
      serial_data_lanes_p == '0)
      else $error("data sent before lock");

   COV_RUN:   cover property (st_ff.state == ST_ACQUIRE ##1 st_ff.state == ST_RUN);
   COV_SLOT6: cover property (st_ff.state == ST_RUN && st_ff.slot == PTX_LAST_SLOT);
   COV_SLEEP: cover property (st_ff.state == ST_RUN ##1 st_ff.state == ST_SLEEP);
   COV_LOST:  cover property (st_ff.state == ST_RUN && clk_lost);

endmodule

// *** ptx_pkg.sv ***
// Constants and carrier types for the serial display link transmitter
package ptx_pkg;

   // ==========================================================
   // Link geometry
   localparam int PTX_LANES      = 4;
   localparam int PTX_SLOTS      = 7;
   localparam int PTX_WORD_W     = PTX_LANES * PTX_SLOTS;
   localparam int PTX_SLOT_W     = 3;
   // Forwarded clock is high in slots below this index
   localparam logic [2:0] PTX_CLK_HI_SLOTS = 3'h4;
   localparam logic [2:0] PTX_LAST_SLOT    = 3'h6;

   // ==========================================================
   // Timing
   localparam int MCLK_MHZ       = 200;
   localparam int PLL_LOCK_MS    = 10;
   localparam int PLL_LOCK_CYC   = PLL_LOCK_MS * 1000 * MCLK_MHZ;
   localparam int SLEEP_DELAY_NS = 100;
   localparam int SLEEP_DELAY_CYC = (SLEEP_DELAY_NS * MCLK_MHZ) / 1000;
   // Period counter width; saturation means the pixel clock stopped
   localparam int PER_W          = 8;
   localparam logic [PER_W-1:0] PER_MAX = 8'hFF;
   localparam int LOCK_W         = 22;

   // ==========================================================
   // Carrier of the 28 parallel inputs
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
      logic       line_sync;
      logic       frame_sync;
      logic       data_valid_flag;
      logic       spare_control;
   } ptx_pixel_t;

   typedef enum logic [2:0] {
      ST_SLEEP   = 3'h1,
      ST_ACQUIRE = 3'h2,
      ST_RUN     = 3'h4
   } ptx_state_t;

   // Differential link outputs
   typedef struct packed {
      logic [PTX_LANES-1:0] lane_p;
      logic [PTX_LANES-1:0] lane_n;
      logic                 clk_p;
      logic                 clk_n;
      logic                 oe;
   } ptx_link_t;

endpackage

// *** ptx_sync.sv ***
// Two-stage synchroniser for a group of pins
`timescale 1ns/100ps
module ptx_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // Pins and synchronised copy
   input  wire logic [WIDTH-1:0] pins,
   output      logic [WIDTH-1:0] pins_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } ptx_sync_st_t;

   ptx_sync_st_t st_ff;
   ptx_sync_st_t nxt_st;

   // First stage feeds only the second stage
   always_comb begin
      nxt_st.meta   = pins;
      nxt_st.stable = st_ff.meta;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pins_sync = st_ff.stable;

endmodule

// *** ptx_rx_model.sv ***
// Behavioural receiver that recovers words from the four-lane serial display link
`timescale 1ns/100ps
module ptx_rx_model
   import ptx_pkg::*;
(
   // Clock
   input  wire logic                  mclk,
   // Resolved link wires
   input  wire logic [PTX_LANES-1:0]  lane_p,
   input  wire logic                  clk_p,
   // Recovered word
   output      logic [PTX_WORD_W-1:0] word,
   output      logic [PTX_SLOTS-1:0]  clk_pat,
   output      logic                  word_vld
);
   int unsigned cnt;
   int unsigned per;
   int          slot;
   logic        clk_q;

   initial begin
      cnt      = 0;
      per      = 0;
      slot     = PTX_SLOTS;
      clk_q    = 1'b0;
      word     = '0;
      clk_pat  = '0;
      word_vld = 1'b0;
   end

   // ==========================================================
   // Slot recovery
   // Slot centres use the previous period, so the first frame after a gap is unreliable
   always @(posedge mclk) begin
      word_vld <= 1'b0;
      if (clk_p === 1'b1 && clk_q !== 1'b1) begin
         per  = cnt;
         cnt  = 0;
         slot = 0;
      end else begin
         cnt = cnt + 1;
      end
      if (slot < PTX_SLOTS && cnt * 14 >= (2 * slot + 1) * per) begin
         for (int l = 0; l < PTX_LANES; l++) begin
            word[l * PTX_SLOTS + slot] <= lane_p[l];
         end
         clk_pat[slot] <= clk_p;
         word_vld      <= (slot == PTX_SLOTS - 1);
         slot = slot + 1;
      end
      clk_q = clk_p;
   end
endmodule

// *** ptx_serial_tx_tb.sv ***
// Self-checking bench for the serial display link transmitter
`timescale 1ns/100ps
module ptx_serial_tx_tb;
   import ptx_pkg::*;
   localparam int LOCK_T = 64;
   localparam int PIX_P  = 25;   // 125 ns pixel clock at 200 MHz
   localparam int T_MAX  = 12000;
   logic                  mclk, rst_n, sleep_n, en, armed;
   logic                  pclk = 1'b0;
   ptx_pixel_t            pix = '0;
   logic [PTX_LANES-1:0]  lp, ln;
   logic                  oe_l, ckp, ckn, oe_c, locked, vld;
   logic [PTX_WORD_W-1:0] rx_word;
   logic [PTX_SLOTS-1:0]  rx_pat;
   wire  [PTX_LANES-1:0]  lane_w = oe_l ? lp : 4'hZ;
   wire                   ckp_w  = oe_c ? ckp : 1'bZ;
   int                    n_fail = 0, checks_done = 0, pcnt = 0, widx = 0, cyc = 0, n;
   int                    seed = 92231;
   logic [PTX_WORD_W-1:0] q[$];

   ptx_serial_tx #(.LOCK_CYC(LOCK_T)) i_ptx_serial_tx (.mclk(mclk), .rst_n(rst_n),
      .parallel_pixel_inputs(pix), .pixel_shift_clock_in(pclk), .sleep_control_n(sleep_n),
      .serial_data_lanes_p(lp), .serial_data_lanes_n(ln), .serial_data_lanes_oe(oe_l),
      .forwarded_link_clock_p(ckp), .forwarded_link_clock_n(ckn),
      .forwarded_link_clock_oe(oe_c), .link_locked(locked));
   ptx_rx_model i_ptx_rx_model (.mclk(mclk), .lane_p(lane_w), .clk_p(ckp_w),
      .word(rx_word), .clk_pat(rx_pat), .word_vld(vld));

   // ==========================================================
   // Helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Walking ones expose any slip in the lane and slot order
   function automatic logic [PTX_WORD_W-1:0] next_word(input int k, input logic [31:0] r);
      if (k == 0) return 28'hFFFFFFF;
      if (k == 1) return 28'h0000000;
      if (k == 2) return 28'hAAAAAAA;
      if (k < 31) return 28'h0000001 << (k - 3);
      return r[27:0];
   endfunction

   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   // ==========================================================
   // Pixel source: 13 high and 12 low of 25 cycles, data moves on the falling edge
   always @(posedge mclk) begin
      pcnt <= (pcnt == PIX_P - 1) ? 0 : pcnt + 1;
      pclk <= (pcnt == PIX_P - 1) || (pcnt < 12);
      if (pcnt == 12) begin
         pix  <= ptx_pixel_t'(next_word(widx, $random(seed)));
         widx <= widx + 1;
      end
      if (pcnt == PIX_P - 1 && en) q.push_back(pix);
   end

   // ==========================================================
   // Compare recovered words against what was presented
   always @(posedge mclk) begin
      if (!en) armed <= 1'b0;
      else if (ckp_w === 1'b1 && q.size() > 0) armed <= 1'b1;
      if (vld === 1'b1 && armed === 1'b1 && q.size() > 0) begin
         check("word", 32'(rx_word), 32'(q.pop_front()));
         check("clk_slots", 32'(rx_pat), 32'h0F);
         check("complement", 32'({ln, ckn} ^ {lp, ckp}), 32'h1F);
      end
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == T_MAX) begin
         n_fail++;
         report_and_stop();
      end
   end

   // Lock wait, then a burst of frames
   task automatic run_phase();
      n = 0;
      while (oe_l !== 1'b1 && n < 50) begin
         tick();
         n++;
      end
      check("pre_lock", 32'({lp, ckp, locked}), 32'h0);
      n = 0;
      while (locked !== 1'b1 && n < LOCK_T + 200) begin
         tick();
         n++;
      end
      check("lock_min", 32'(n >= LOCK_T), 32'h1);
      check("lock_max", 32'(n <= LOCK_T + 60), 32'h1);
      repeat (60) tick();
      @(posedge mclk iff pcnt == PIX_P - 1);
      en <= 1'b1;
      repeat (40 * PIX_P) tick();
   endtask

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, en} = '0;
      sleep_n = 1'b1;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      tick();
      check("oe_reset", 32'({oe_l, oe_c, locked}), 32'h0);
      run_phase();
      sleep_n <= 1'b0;
      en      <= 1'b0;
      n = 0;
      while ((oe_l !== 1'b0 || oe_c !== 1'b0) && n < 40) begin
         tick();
         n++;
      end
      check("sleep_delay", 32'(n <= SLEEP_DELAY_CYC), 32'h1);
      repeat (100) tick();
      check("asleep", 32'({oe_l, oe_c, locked}), 32'h0);
      q.delete();
      sleep_n <= 1'b1;
      run_phase();
      report_and_stop();
   end
endmodule
